// ### core/rtr_defines.svh
// Offsets, fields, reset values and timing counts of the serial router
//==============================================================
`ifndef RTR_DEFINES_SVH
`define RTR_DEFINES_SVH
// ============================================================
// Register word offsets
`define RTR_OFF_CTRL    8'h00
`define RTR_OFF_TIMING  8'h04
`define RTR_OFF_TIMEOUT 8'h08
`define RTR_OFF_POLL    8'h0C
`define RTR_OFF_STATUS  8'h10
// ============================================================
// Field positions
`define RTR_POLL_GO_BIT 8
// ============================================================
// Reset values
`define RTR_RST_ATTEMPTS 4'h3
`define RTR_RST_REPLY_TO 16'h00C8
// ============================================================
// Drop number limits (99, 100, 199, 201, 255)
`define RTR_NET_MAX   8'h63
`define RTR_MB_BASE   8'h64
`define RTR_MB_MAX    8'hC7
`define RTR_WILDCARD  8'hC9
`define RTR_MB_LOCAL  8'hFF
// ============================================================
// Timing: one tick is 1000 us at a 100 ns clock
`define RTR_TICK_US   1000
`define RTR_CLK_NS    100
`define RTR_TICK_CYC  (`RTR_TICK_US * 1000 / `RTR_CLK_NS)
`endif

// ### core/rtr_pkg.sv
// Types shared by the serial router modules
package rtr_pkg;
  // ============================================================
  // Transfer state, Gray coded from idle through pause
  typedef enum logic [2:0] {
    S_IDLE  = 3'h0,
    S_HSHK  = 3'h1,
    S_SEND  = 3'h3,
    S_WAIT  = 3'h2,
    S_PAUSE = 3'h6
  } rtr_fsm_t;

  // Routing verdict for one message
  typedef enum logic [2:0] {
    ACT_NONE  = 3'h0,
    ACT_NET   = 3'h1,
    ACT_MB    = 3'h2,
    ACT_LOCAL = 3'h3,
    ACT_TABLE = 3'h4,
    ACT_FWD   = 3'h5,
    ACT_ERR   = 3'h6,
    ACT_DROP  = 3'h7
  } rtr_act_t;

  // Message descriptor from the framer / routing core
  typedef struct packed {
    logic       rt_frame_ok;  // Routed-protocol framing checked good
    logic       mb_frame_ok;  // Modbus RTU framing checked good
    logic       from_line;    // Received on this serial line
    logic       has_route;    // Routed message carries a route
    logic [7:0] first_drop;   // First route drop
    logic [7:0] next_drop;    // Drop after the port's own drop
    logic [7:0] mb_addr;      // Modbus slave address
  } rtr_msg_t;

  // Verdict handed back
  typedef struct packed {
    rtr_act_t   act;          // What to do
    logic [7:0] addr;         // Target drop or slave address for the line
  } rtr_dec_t;

  // Whole state of the router
  typedef struct packed {
    rtr_fsm_t   fsm;
    logic       mode;         // 0 mixed multidrop master, 1 dual slave
    logic [7:0] own_drop;
    logic [7:0] net_id;
    logic [3:0] attempts;
    logic [7:0] hs_delay;
    logic [7:0] pause;
    logic [7:0] msg_count;
    logic [15:0] reply_to;
    logic [15:0] poll_iv;
    logic [7:0] poll_addr;
    logic       poll_req;
    logic [15:0] cnt;
    logic [15:0] poll_cnt;
    logic [3:0] tries;
    logic [7:0] sent;
    logic       cur_net;
    logic [7:0] cur_addr;
    logic       pready;
    logic       pslverr;
    logic [31:0] prdata;
    logic       msg_ready;
    logic       dec_valid;
    rtr_dec_t   dec;
    logic       rts;
    logic       tx_start;
    logic       done;
    logic       timeout;
  } rtr_st_t;
endpackage : rtr_pkg

// ### core/rtr_sync.sv
// Two flip-flop synchroniser for a pin input
`timescale 1ns/10ps
module rtr_sync (
  input  wire logic clk_in,     // Clock
  input  wire logic reset_n_in, // Synchronous reset, active low
  input  wire logic d_in,       // Asynchronous level
  output logic      q_out       // Synchronised level
);
  logic [1:0] st;      // Stage 0 feeds stage 1 only
  logic [1:0] next_st; // Next stages

  // ============================================================
  // Shift chain
  always_comb begin
    next_st = reset_n_in ? {st[0], d_in} : 2'h0;
  end

  always_ff @(posedge clk_in) begin
    st <= next_st;
  end

  assign q_out = st[1];
endmodule : rtr_sync

// ### core/rtr_tick.sv
// Prescaler producing a one-cycle tick for the millisecond timers
`timescale 1ns/10ps
module rtr_tick #(
  parameter int unsigned CYCLES = 10000  // Clock cycles per tick
) (
  input  wire logic clk_in,     // Clock
  input  wire logic reset_n_in, // Synchronous reset, active low
  output logic      tick_out    // One-cycle tick
);
  if (CYCLES < 2 || CYCLES > 65536) begin : g_chk
    $error("tick period out of range");
  end

  typedef struct packed {
    logic [15:0] cnt;
    logic        tick;
  } rtr_tick_st_t;

  rtr_tick_st_t st;      // Counter and tick
  rtr_tick_st_t next_st; // Next value

  // ============================================================
  // Wrap counter
  always_comb begin
    next_st = st;
    next_st.tick = 1'b0;
    if (st.cnt == 16'(CYCLES - 1)) begin
      next_st.cnt  = 16'h0000;
      next_st.tick = 1'b1;
    end else begin
      next_st.cnt = st.cnt + 16'h0001;
    end
    if (!reset_n_in) begin
      next_st = '0;
    end
  end

  always_ff @(posedge clk_in) begin
    st <= next_st;
  end

  assign tick_out = st.tick;
endmodule : rtr_tick

// ### core/rtr_router.sv
// Mixed multidrop / dual slave message router with APB registers
//
// The register addresses and the APB register port were left to the implementer.
`timescale 1ns/10ps
`include "rtr_defines.svh"
module rtr_router import rtr_pkg::*; #(
  parameter int unsigned TICK_CYCLES = `RTR_TICK_CYC  // Cycles per 1 ms tick
) (
  input  wire logic        clk_in,           // 10 MHz clock
  input  wire logic        reset_n_in,       // Synchronous reset, active low
  input  wire logic        psel_in,          // APB select
  input  wire logic        penable_in,       // APB enable
  input  wire logic        pwrite_in,        // APB write
  input  wire logic [7:0]  paddr_in,         // APB byte address
  input  wire logic [31:0] pwdata_in,        // APB write data
  output logic [31:0]      prdata_out,       // APB read data
  output logic             pready_out,       // APB ready
  output logic             pslverr_out,      // APB error
  input  wire logic        msg_valid_in,     // Message offered
  input  wire rtr_msg_t    msg_in,           // Message descriptor
  output logic             msg_ready_out,    // Message taken when high
  output logic             dec_valid_out,    // Verdict pulse
  output rtr_dec_t         dec_out,          // Verdict
  output logic             rts_out,          // Request to send
  input  wire logic        cts_in,           // Clear to send pin
  output logic             tx_start_out,     // Start serialiser pulse
  output logic             tx_net_out,       // 1 network packet, 0 Modbus
  output logic [7:0]       tx_addr_out,      // Target drop or slave
  input  wire logic        tx_done_in,       // Serialiser finished pulse
  input  wire logic        reply_in,         // Reply received pulse
  output logic             xfer_done_out,    // Exchange finished pulse
  output logic             xfer_timeout_out, // Exchange ended without reply
  output logic [7:0]       net_id_out        // Network identifier to framer
);
  if (TICK_CYCLES < 2 || TICK_CYCLES > 65536) begin : g_chk
    $error("TICK_CYCLES out of range");
  end

  rtr_st_t st;      // Registered state
  rtr_st_t next_st; // Next state
  logic    cts_s;   // Synchronised clear to send
  logic    tick;    // Millisecond tick
  logic    acc;     // Message taken this cycle

  // ============================================================
  // Pin synchroniser and timer prescaler
  rtr_sync u_cts (
    .clk_in     (clk_in),
    .reset_n_in (reset_n_in),
    .d_in       (cts_in),
    .q_out      (cts_s)
  );

  rtr_tick #(.CYCLES(TICK_CYCLES)) u_tick (
    .clk_in     (clk_in),
    .reset_n_in (reset_n_in),
    .tick_out   (tick)
  );

  assign acc = msg_valid_in & st.msg_ready;

  // ============================================================
  // Routing verdict for one message
  function automatic rtr_dec_t route_dec(input rtr_msg_t m, input logic mode, input logic [7:0] own);
    rtr_dec_t d;
    d.act  = ACT_DROP;
    d.addr = 8'h00;
    if (!mode) begin
      // Mixed multidrop master
      if (m.from_line) begin
        d.act = m.rt_frame_ok ? ACT_FWD : ACT_DROP;
      end else if (m.next_drop <= `RTR_NET_MAX) begin
        d.act  = ACT_NET;
        d.addr = m.next_drop;
      end else if (m.next_drop <= `RTR_MB_MAX) begin
        d.act  = ACT_MB;
        d.addr = 8'(m.next_drop - `RTR_MB_BASE);
      end else begin
        d.act = ACT_ERR;
      end
    end else if (m.rt_frame_ok) begin
      // Routed protocol chosen by its framing
      if (!m.has_route) begin
        d.act = ACT_LOCAL;
      end else if (m.first_drop == own || m.first_drop == `RTR_WILDCARD) begin
        d.act = ACT_FWD;
      end else begin
        d.act = ACT_ERR;
      end
    end else if (m.mb_frame_ok) begin
      // Modbus RTU chosen by its framing
      d.addr = m.mb_addr;
      d.act  = (m.mb_addr == `RTR_MB_LOCAL) ? ACT_LOCAL : ACT_TABLE;
    end
    return d;
  endfunction : route_dec

  // ============================================================
  // Next state: registers, poll timer, transfer sequence
  always_comb begin
    next_st           = st;
    next_st.pready    = psel_in & ~penable_in;
    next_st.pslverr   = 1'b0;
    next_st.prdata    = 32'h0000_0000;
    next_st.dec_valid = 1'b0;
    next_st.tx_start  = 1'b0;
    next_st.done      = 1'b0;
    // Read data is latched in the setup cycle; zero wait states
    if (psel_in && !penable_in && !pwrite_in) begin
      unique case (paddr_in)
        `RTR_OFF_CTRL:    next_st.prdata = {4'h0, st.attempts, st.net_id, st.own_drop, 7'h00, st.mode};
        `RTR_OFF_TIMING:  next_st.prdata = {8'h00, st.msg_count, st.pause, st.hs_delay};
        `RTR_OFF_TIMEOUT: next_st.prdata = {st.poll_iv, st.reply_to};
        `RTR_OFF_POLL:    next_st.prdata = {23'h000000, st.poll_req, st.poll_addr};
        `RTR_OFF_STATUS:  next_st.prdata = {8'h00, st.sent, 4'h0, st.tries, 1'b0, st.timeout,
                                            cts_s, st.rts, 1'b0, st.fsm};
        default:          next_st.pslverr = 1'b1;
      endcase
    end else if (psel_in && !penable_in) begin
      unique case (paddr_in)
        `RTR_OFF_CTRL, `RTR_OFF_TIMING, `RTR_OFF_TIMEOUT, `RTR_OFF_POLL: next_st.pslverr = 1'b0;
        default: next_st.pslverr = 1'b1;  // Status is read only
      endcase
    end
    // Transfer sequence
    unique case (st.fsm)
      S_IDLE: begin
        if (acc) begin
          next_st.dec       = route_dec(msg_in, st.mode, st.own_drop);
          next_st.dec_valid = 1'b1;
          if (next_st.dec.act == ACT_NET || next_st.dec.act == ACT_MB) begin
            next_st.cur_net  = (next_st.dec.act == ACT_NET);
            next_st.cur_addr = next_st.dec.addr;
            next_st.tries    = 4'h0;
            next_st.cnt      = 16'h0000;
            next_st.rts      = 1'b1;
            next_st.fsm      = S_HSHK;
          end
        end else if (st.poll_req && !st.mode) begin
          // Poll only in master mode; the slave port never initiates
          next_st.poll_req = 1'b0;
          next_st.cur_net  = 1'b1;
          next_st.cur_addr = st.poll_addr;
          next_st.tries    = 4'h0;
          next_st.cnt      = 16'h0000;
          next_st.rts      = 1'b1;
          next_st.fsm      = S_HSHK;
        end
      end
      S_HSHK: begin
        // Waits for clear to send however long it takes
        if (st.cnt >= {8'h00, st.hs_delay} && cts_s) begin
          next_st.tx_start = 1'b1;
          next_st.fsm      = S_SEND;
        end else if (tick && st.cnt < {8'h00, st.hs_delay}) begin
          next_st.cnt = st.cnt + 16'h0001;
        end
      end
      S_SEND: begin
        if (tx_done_in) begin
          next_st.rts = 1'b0;
          next_st.cnt = 16'h0000;
          next_st.fsm = S_WAIT;
        end
      end
      S_WAIT: begin
        if (reply_in) begin
          next_st.done    = 1'b1;
          next_st.timeout = 1'b0;
          next_st.cnt     = 16'h0000;
          next_st.sent    = st.sent + 8'h01;
          next_st.fsm     = S_PAUSE;
        end else if (tick) begin
          if (st.cnt + 16'h0001 >= st.reply_to) begin
            if (st.cur_net && st.tries + 4'h1 < st.attempts) begin
              next_st.tries = st.tries + 4'h1;
              next_st.cnt   = 16'h0000;
              next_st.rts   = 1'b1;
              next_st.fsm   = S_HSHK;
            end else begin
              // Modbus frames end here on their first timeout
              next_st.done    = 1'b1;
              next_st.timeout = 1'b1;
              next_st.cnt     = 16'h0000;
              next_st.sent    = st.sent + 8'h01;
              next_st.fsm     = S_PAUSE;
            end
          end else begin
            next_st.cnt = st.cnt + 16'h0001;
          end
        end
      end
      S_PAUSE: begin
        // Pause after each group of message-count exchanges
        if (st.msg_count != 8'h00 && st.sent < st.msg_count) begin
          next_st.fsm = S_IDLE;
        end else if (st.cnt >= {8'h00, st.pause}) begin
          next_st.sent = 8'h00;
          next_st.fsm  = S_IDLE;
        end else if (tick) begin
          next_st.cnt = st.cnt + 16'h0001;
        end
      end
      default: begin
        next_st.rts = 1'b0;
        next_st.fsm = S_IDLE;
      end
    endcase
    // Poll timer after the launch, so a tick that meets a launch is kept
    if (tick && st.poll_iv != 16'h0000 && !st.mode) begin
      if (st.poll_cnt + 16'h0001 >= st.poll_iv) begin
        next_st.poll_cnt = 16'h0000;
        next_st.poll_req = 1'b1;
      end else begin
        next_st.poll_cnt = st.poll_cnt + 16'h0001;
      end
    end
    next_st.msg_ready = (next_st.fsm == S_IDLE) && !(st.fsm == S_IDLE && !acc && st.poll_req && !st.mode);
    // Register writes take effect at the access edge; a poll write wins
    if (psel_in && penable_in && st.pready && pwrite_in) begin
      unique case (paddr_in)
        `RTR_OFF_CTRL: begin
          next_st.mode     = pwdata_in[0];
          next_st.own_drop = pwdata_in[15:8];
          next_st.net_id   = pwdata_in[23:16];
          next_st.attempts = pwdata_in[27:24];
        end
        `RTR_OFF_TIMING: begin
          next_st.hs_delay  = pwdata_in[7:0];
          next_st.pause     = pwdata_in[15:8];
          next_st.msg_count = pwdata_in[23:16];
        end
        `RTR_OFF_TIMEOUT: begin
          next_st.reply_to = pwdata_in[15:0];
          next_st.poll_iv  = pwdata_in[31:16];
        end
        `RTR_OFF_POLL: begin
          next_st.poll_addr = pwdata_in[7:0];
          if (pwdata_in[`RTR_POLL_GO_BIT]) begin
            next_st.poll_req = 1'b1;
          end
        end
        default: next_st.pslverr = 1'b0;
      endcase
    end
    if (!reset_n_in) begin
      next_st          = '0;
      next_st.attempts = `RTR_RST_ATTEMPTS;
      next_st.reply_to = `RTR_RST_REPLY_TO;
    end
  end

  // ============================================================
  // State register
  always_ff @(posedge clk_in) begin
    st <= next_st;
  end

  // Outputs straight from flip-flops
  assign prdata_out       = st.prdata;
  assign pready_out       = st.pready;
  assign pslverr_out      = st.pslverr;
  assign msg_ready_out    = st.msg_ready;
  assign dec_valid_out    = st.dec_valid;
  assign dec_out          = st.dec;
  assign rts_out          = st.rts;
  assign tx_start_out     = st.tx_start;
  assign tx_net_out       = st.cur_net;
  assign tx_addr_out      = st.cur_addr;
  assign xfer_done_out    = st.done;
  assign xfer_timeout_out = st.timeout;
  assign net_id_out       = st.net_id;   // Framer stamps every packet

  // ============================================================
  // Assertions
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!reset_n_in);

  sequence s_mix_acc;
    acc && !st.mode && !msg_in.from_line;
  endsequence

  property p_net_range;
    s_mix_acc and (msg_in.next_drop <= 8'h63) |=> dec_valid_out && dec_out.act == ACT_NET;
  endproperty
  a_net_range: assert property (p_net_range) else $error("drop 0-99 not sent as packet");

  property p_mb_addr;
    s_mix_acc and (msg_in.next_drop >= 8'h64 && msg_in.next_drop <= 8'hC7)
      |=> dec_out.act == ACT_MB && dec_out.addr == $past(msg_in.next_drop) - 8'h64;
  endproperty
  a_mb_addr: assert property (p_mb_addr) else $error("Modbus address not drop minus 100");

  property p_no_repeat;
    s_mix_acc and (msg_in.next_drop >= 8'h64) |=> dec_out.act != ACT_NET;
  endproperty
  a_no_repeat: assert property (p_no_repeat) else $error("high drop sent as repeater");

  property p_no_mb_slave;
    acc && !st.mode && msg_in.from_line && !msg_in.rt_frame_ok |=> dec_out.act == ACT_DROP;
  endproperty
  a_no_mb_slave: assert property (p_no_mb_slave) else $error("Modbus slave request taken");

  property p_mb_noretry;
    st.fsm == S_WAIT && !st.cur_net |=> st.fsm == S_WAIT || st.fsm == S_PAUSE;
  endproperty
  a_mb_noretry: assert property (p_mb_noretry) else $error("Modbus frame retried");

  sequence s_cts_seen;
    rts_out && cts_s;
  endsequence

  property p_hshk;
    $rose(tx_start_out) |-> rts_out && $past(cts_s) && $past(st.fsm) == S_HSHK;
  endproperty
  a_hshk: assert property (p_hshk) else $error("sent without handshake");

  property p_hshk_zero;
    (st.fsm == S_HSHK && st.hs_delay == 8'h00) and s_cts_seen |=> tx_start_out;
  endproperty
  a_hshk_zero: assert property (p_hshk_zero) else $error("zero delay did not send on cts");

  property p_local_route;
    acc && st.mode && msg_in.rt_frame_ok && !msg_in.has_route |=> dec_out.act == ACT_LOCAL;
  endproperty
  a_local_route: assert property (p_local_route) else $error("routeless message not local");

  property p_mb_local;
    acc && st.mode && !msg_in.rt_frame_ok && msg_in.mb_frame_ok && msg_in.mb_addr == 8'hFF
      |=> dec_out.act == ACT_LOCAL;
  endproperty
  a_mb_local: assert property (p_mb_local) else $error("address 255 not local");

  property p_answer;
    acc && st.mode && msg_in.rt_frame_ok
      |=> dec_valid_out && (dec_out.act == ACT_LOCAL || dec_out.act == ACT_FWD || dec_out.act == ACT_ERR);
  endproperty
  a_answer: assert property (p_answer) else $error("routed message left unanswered");
endmodule : rtr_router

// ### verification/rtr_line_model.sv
// Far-side model: modem handshake, serialiser and remote slave
`timescale 1ns/10ps
module rtr_line_model (
  input  wire logic clk_in,      // Clock
  input  wire logic rts_in,      // Request to send
  input  wire logic tx_start_in, // Frame launch pulse
  input  wire logic reply_en_in, // Remote node answers
  output logic      cts_out,     // Clear to send
  output logic      tx_done_out, // Frame sent pulse
  output logic      reply_out    // Reply pulse
);
  // ============================================================
  // Modem lag and frame timing
  logic [2:0] rts_dly = 3'h0; // Modem turn-on lag
  logic [3:0] tx_cnt  = 4'h0; // Cycles since launch, 0 idle
  // Clear falls with request at once, so no stale grant lingers
  assign cts_out = rts_dly[2] & rts_in;
  assign tx_done_out = (tx_cnt == 4'h4);
  // The remote node answers only when reply_en_in is set, one reply per query
  assign reply_out = reply_en_in & (tx_cnt == 4'h8);
  always_ff @(posedge clk_in) begin
    rts_dly <= {rts_dly[1:0], rts_in};
    if (tx_start_in) begin
      tx_cnt <= 4'h1;
    end else if (tx_cnt != 4'h0) begin
      tx_cnt <= tx_cnt + 4'h1;
    end
  end
endmodule : rtr_line_model

// ### verification/rtr_router_tb.sv
// Self-checking bench for the serial message router
`timescale 1ns/10ps
module rtr_router_tb import rtr_pkg::*; ();
  // ============================================================
  // Signals
  logic        clk = 1'b0, rst_n = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic        msg_valid = 1'b0, reply_en = 1'b0, cts, tx_done, reply, pready, pslverr;
  logic        msg_ready, dec_valid, rts, tx_start, tx_net, xdone, xto, err;
  logic [7:0]  paddr = 8'h00, tx_addr, net_id;
  logic [8:0]  xk;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  rtr_msg_t    msg = '0;
  rtr_dec_t    dec;
  int          error_cnt = 0, checked = 0, cyc = 0, s, l;
  rtr_router #(.TICK_CYCLES(4)) rtr_router_i (
    .clk_in(clk), .reset_n_in(rst_n), .psel_in(psel), .penable_in(penable), .pwrite_in(pwrite),
    .paddr_in(paddr), .pwdata_in(pwdata), .prdata_out(prdata), .pready_out(pready),
    .pslverr_out(pslverr), .msg_valid_in(msg_valid), .msg_in(msg), .msg_ready_out(msg_ready),
    .dec_valid_out(dec_valid), .dec_out(dec), .rts_out(rts), .cts_in(cts), .tx_start_out(tx_start),
    .tx_net_out(tx_net), .tx_addr_out(tx_addr), .tx_done_in(tx_done), .reply_in(reply),
    .xfer_done_out(xdone), .xfer_timeout_out(xto), .net_id_out(net_id));
  rtr_line_model rtr_line_model_i (.clk_in(clk), .rts_in(rts), .tx_start_in(tx_start),
    .reply_en_in(reply_en), .cts_out(cts), .tx_done_out(tx_done), .reply_out(reply));
  // ============================================================
  // Shared tasks
  task automatic chk(input string what, input logic [31:0] seen, exp);
    checked++;
    if (seen !== exp) begin
      error_cnt++;
      $display("[ERR] %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk
  task automatic results;
    $display("Checks %0d mismatches %0d", checked, error_cnt);
    if (error_cnt == 0 && checked > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : results
  // APB transfer held until pready is seen at a rising edge
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do @(posedge clk); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  // Offer one message, wait for its verdict
  task automatic send(input rtr_msg_t m, input logic rep);
    @(posedge clk);
    msg_valid <= 1'b1;
    msg <= m;
    reply_en <= rep;
    do @(posedge clk); while (msg_ready !== 1'b1);
    msg_valid <= 1'b0;
    do @(posedge clk); while (dec_valid !== 1'b1);
  endtask : send
  // Follow one exchange: launches, request lead time, line target
  task automatic xfer;
    s = 0;
    l = 0;
    do begin
      @(negedge clk);
      if (tx_start === 1'b1) begin
        s++;
        xk = {tx_net, tx_addr};
        chk("clear at launch", cts, 1'b1);
      end
      if (rts === 1'b1 && s == 0) l++;
    end while (xdone !== 1'b1);
  endtask : xfer
  // ============================================================
  // Scenarios
  task automatic t_mixed;
    logic [7:0] d[5] = '{8'h00, 8'h63, 8'h64, 8'h65, 8'hC7};
    logic       n;
    apb(1'b0, 8'h08, 32'h0);
    chk("timeout reset", rd, 32'h000000C8);
    apb(1'b0, 8'h20, 32'h0);
    chk("unmapped", err, 1'b1);
    apb(1'b1, 8'h10, 32'h0);
    chk("status write", err, 1'b1);
    apb(1'b1, 8'h00, 32'h022A3500);
    apb(1'b1, 8'h08, 32'h00000004);
    chk("network_identifier", net_id, 8'h2A);
    foreach (d[i]) begin
      n = d[i] < 8'h64;
      send({4'h9, 8'h00, d[i], 8'h00}, 1'b1);
      chk("verdict", dec.act, n ? ACT_NET : ACT_MB);
      xfer();
      chk("line target", xk, {n, n ? d[i] : d[i] - 8'h64});
      chk("tries", s, 1);
    end
    send({4'h9, 8'h00, 8'hC8, 8'h00}, 1'b1);
    chk("out of range", dec.act, ACT_ERR);
    send({4'h9, 8'h00, 8'h69, 8'h00}, 1'b0);
    xfer();
    chk("modbus tries", {s[3:0], xto}, 5'h03);
    send({4'h9, 8'h00, 8'h12, 8'h00}, 1'b0);
    xfer();
    chk("network tries", {s[3:0], xto}, 5'h05);
    send({4'h6, 24'h000005}, 1'b1);
    chk("slave request", dec.act, ACT_DROP);
    $display("t_mixed done");
  endtask : t_mixed
  task automatic t_timing;
    // Four ticks of four cycles: launch 13 to 16 cycles after the verdict
    apb(1'b1, 8'h04, 32'h00020004);
    send({4'h9, 8'h00, 8'h07, 8'h00}, 1'b1);
    xfer();
    chk("packet delay", l >= 13 && l <= 16, 1'b1);
    apb(1'b0, 8'h10, 32'h0);
    chk("sent count", rd[23:16], 8'h01);
    send({4'h9, 8'h00, 8'h6A, 8'h00}, 1'b1);
    xfer();
    chk("frame delay", l >= 13 && l <= 16, 1'b1);
    apb(1'b1, 8'h0C, 32'h00000105);
    xfer();
    chk("poll target", xk, {1'b1, 8'h05});
    apb(1'b1, 8'h08, 32'h00020004);
    xfer();
    chk("auto poll", xk, {1'b1, 8'h05});
    apb(1'b1, 8'h08, 32'h00000004);
    $display("t_timing done");
  endtask : t_timing
  task automatic t_dual;
    rtr_msg_t m[8] = '{{4'hA, 24'h0}, {4'hB, 24'h350000}, {4'hB, 24'hC90000}, {4'hB, 24'h100000},
                       {4'h6, 24'h0000FF}, {4'h6, 24'h000005}, {4'h2, 24'h0}, {4'hE, 24'h0}};
    rtr_act_t a[8] = '{ACT_LOCAL, ACT_FWD, ACT_FWD, ACT_ERR, ACT_LOCAL, ACT_TABLE, ACT_DROP, ACT_LOCAL};
    apb(1'b1, 8'h00, 32'h02003501);
    foreach (m[i]) begin
      send(m[i], 1'b1);
      chk("dual verdict", dec.act, a[i]);
    end
    $display("t_dual done");
  endtask : t_dual
  // ============================================================
  // Clock, hang guard and main sequence
  initial begin
    forever #50 clk = ~clk;
  end
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      error_cnt++;
      results();
    end
  end
  initial begin
    repeat (20) @(posedge clk);
    rst_n <= 1'b1;
    t_mixed();
    t_timing();
    t_dual();
    results();
  end
endmodule : rtr_router_tb
